// File: rlcs_pkg.sv
package rlcs_pkg;
   // Variant selection
   typedef enum logic [1:0] {
      RLCS_VAR_SINGLE,
      RLCS_VAR_DUAL,
      RLCS_VAR_OUTPUT
   } rlcs_variant_t;

   // Switch bank width (dual variant uses pins 2 to 6)
   localparam int          SW_W          = 6;
   localparam int          WORD_W        = 16;
   // Switch positions (0-based index = pin number - 1)
   localparam int          SGL_DELAY_SW  = 3;
   localparam int          SGL_CLEAR_SW  = 2;
   localparam int          SGL_MODE_SW   = 1;
   localparam int          SGL_LAMP_SW   = 0;
   localparam int          DUAL_DELAY_SW = 5;
   localparam int          DUAL_CLEAR_SW = 4;
   localparam int          DUAL_MODE_SW  = 3;
   localparam int          DUAL_LAMP1_SW = 2;
   localparam int          DUAL_LAMP2_SW = 1;
   // Factory defaults of the switch bank
   localparam logic [5:0]  SGL_SW_DEFAULT  = 6'h01;
   localparam logic [5:0]  DUAL_SW_DEFAULT = 6'h06;
   localparam logic [5:0]  OUT_SW_DEFAULT  = 6'h00;
   // Fault flag position in fault-bit mode
   localparam int          FAULT_BIT     = 15;
   // Delay class figures, in microseconds
   localparam int          RAPID_US      = 3000;
   localparam int          STANDARD_US   = 19200;
   // Power-up link establishment limit
   localparam int          CLK_MHZ       = 100;
   localparam int          EST_LIMIT_US  = 10000;
   localparam int          EST_LIMIT_CYC = EST_LIMIT_US * CLK_MHZ;
   localparam int          EST_CNT_W     = 21;
endpackage

// File: rlcs_chan.sv
`timescale 1ns/1ps
// One input channel: hold or clear on fault, fault bit insertion, lamp gating
module rlcs_chan
   import rlcs_pkg::*;
(
   // Clock and control
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                clkEn,
   // Configuration
   input  wire logic                clearOnFault,
   input  wire logic                faultBitMode,
   input  wire logic                lampEnable,
   input  wire logic                estTimeout,
   // Link side
   input  wire logic [WORD_W-1:0]   linkWord,
   input  wire logic                linkWordValid,
   input  wire logic                linkFault,
   input  wire logic                delayMismatch,
   // Host side
   output logic      [WORD_W-1:0]   inputWord,
   output logic                     faultLamp
);
   logic              established;     // Normal transmission seen since reset
   logic [WORD_W-1:0] held;            // Last good data
   logic              faultFlag;       // Fault condition as host sees it
   wire               rawFault = linkFault | delayMismatch | (~established & estTimeout);
   wire               goodWord = linkWordValid & ~linkFault & ~delayMismatch;
   wire [WORD_W-1:0]  next_held = goodWord ? linkWord : held;
   // Data shown while faulted: held copy or all off
   wire [WORD_W-1:0]  faultData = clearOnFault ? '0 : held;
   // Registered flag, not the raw inputs, picks the data, so the word follows the lamp
   wire [WORD_W-1:0]  dataSel   = ~established ? '0 : (faultFlag ? faultData : held);

   // Capture good words and remember establishment
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         held        <= '0;
         established <= 1'b0;
         faultFlag   <= 1'b0;
      end else if (clkEn) begin
         held        <= next_held;
         established <= established | goodWord;
         faultFlag   <= rawFault;
      end
   end

   // Bit 15 is the fault flag only in fault-bit mode
   always_comb begin
      inputWord = dataSel;
      if (faultBitMode) begin
         inputWord[FAULT_BIT] = faultFlag;
      end
   end

   // Lamp lights only with both fault and enable
   assign faultLamp = faultFlag & lampEnable;
endmodule

// File: rlcs_top.sv
`timescale 1ns/1ps
// Function
// - Ready lamp on while powered
// - Single variant: input fault lamp on fault
// - Single and dual: fast lamp lit for rapid class
// - Clear lamp lit when clearing on fault
// - Fault-bit lamp lit in fault-bit mode
// - Dual: channel 1 lamp on fault
// - Dual: channel 2 lamp on fault
// - Output variant: delay class lamp
// - Switch 4 is delay class
// - Switch 3 handling, switch 2 mode
// - Switch 1 enables single fault lamp
// - Dual: switches 6,5,4 class, handling, mode
// - Dual: switches 3,2 enable lamps
// - Single default: switch 1 on
// - Dual default 2,3 on; output all off
// - Hold keeps inputs, clear forces off
// - Fault-bit mode: bit 15 flags fault
// - Fault after 10 ms without link
// - Delay class mismatch flags fault
module rlcs_top
   import rlcs_pkg::*;
#(
   parameter rlcs_variant_t      VARIANT    = RLCS_VAR_SINGLE,
   parameter int                 EST_CYCLES = EST_LIMIT_CYC
)
(
   // Clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                clkEn,
   // Switch bank, 1 = on, bit 0 = pin 1
   input  wire logic [SW_W-1:0]     switches,
   // Link channels
   input  wire logic [WORD_W-1:0]   link1Word,
   input  wire logic                link1Valid,
   input  wire logic                link1Fault,
   input  wire logic                link1Rapid,
   input  wire logic [WORD_W-1:0]   link2Word,
   input  wire logic                link2Valid,
   input  wire logic                link2Fault,
   input  wire logic                link2Rapid,
   // Host input words
   output logic      [WORD_W-1:0]   input1Word,
   output logic      [WORD_W-1:0]   input2Word,
   // Link delay class as configured
   output logic                     rapidClass,
   // Lamps
   output logic                     readyLamp,
   output logic                     fault_lamp,
   output logic                     fast_delay_lamp,
   output logic                     clear_on_fault_lamp,
   output logic                     fault_bit_mode_lamp,
   output logic                     chan1_fault_lamp,
   output logic                     chan2_fault_lamp,
   output logic                     delay_class_lamp
);
   // Latched configuration, captured once after reset
   logic [SW_W-1:0]       cfg;
   logic                  cfgTaken;
   logic [EST_CNT_W-1:0]  estCnt;      // Power-up establishment timer
   logic                  estTimeout;
   logic [WORD_W-1:0]     w1;
   logic [WORD_W-1:0]     w2;
   logic                  lamp1;
   logic                  lamp2;

   wire isDual = (VARIANT == RLCS_VAR_DUAL);
   wire isOut  = (VARIANT == RLCS_VAR_OUTPUT);
   // Defaults per variant stand until the bank is sampled
   wire [SW_W-1:0] swDefault = isDual ? DUAL_SW_DEFAULT :
                               (isOut ? OUT_SW_DEFAULT : SGL_SW_DEFAULT);
   // Field decode depends on variant
   wire cfgRapid = isDual ? cfg[DUAL_DELAY_SW] : cfg[SGL_DELAY_SW];
   wire cfgClear = ~isOut & (isDual ? cfg[DUAL_CLEAR_SW] : cfg[SGL_CLEAR_SW]);
   wire cfgMode  = ~isOut & (isDual ? cfg[DUAL_MODE_SW] : cfg[SGL_MODE_SW]);
   wire lampEn1  = ~isOut & (isDual ? cfg[DUAL_LAMP1_SW] : cfg[SGL_LAMP_SW]);
   wire lampEn2  = isDual & cfg[DUAL_LAMP2_SW];
   // Unused pins are simply not decoded, so a stray on does nothing
   wire mism1 = link1Rapid ^ cfgRapid;
   wire mism2 = link2Rapid ^ cfgRapid;
   wire [EST_CNT_W-1:0] estLimit = EST_CNT_W'(EST_CYCLES);

   // Sample switches once, the first enabled cycle after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg      <= swDefault;
         cfgTaken <= 1'b0;
      end else if (clkEn && !cfgTaken) begin
         cfg      <= switches;
         cfgTaken <= 1'b1;
      end
   end

   // Count up to the establishment limit after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         estCnt     <= '0;
         estTimeout <= 1'b0;
      end else if (clkEn && !estTimeout) begin
         estCnt     <= estCnt + 1'b1;
         estTimeout <= (estCnt == estLimit - 1'b1);
      end
   end

   // Channel 1 serves single and dual variants
   rlcs_chan u_chan1 (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .clkEn         (clkEn),
      .clearOnFault  (cfgClear),
      .faultBitMode  (cfgMode),
      .lampEnable    (lampEn1),
      .estTimeout    (estTimeout),
      .linkWord      (link1Word),
      .linkWordValid (link1Valid),
      .linkFault     (link1Fault),
      .delayMismatch (mism1),
      .inputWord     (w1),
      .faultLamp     (lamp1)
   );

   // Channel 2 only matters on the dual variant
   rlcs_chan u_chan2 (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .clkEn         (clkEn),
      .clearOnFault  (cfgClear),
      .faultBitMode  (cfgMode),
      .lampEnable    (lampEn2),
      .estTimeout    (estTimeout),
      .linkWord      (link2Word),
      .linkWordValid (link2Valid),
      .linkFault     (link2Fault),
      .delayMismatch (mism2),
      .inputWord     (w2),
      .faultLamp     (lamp2)
   );

   // Host words; unused channels read zero
   assign input1Word          = isOut ? '0 : w1;
   assign input2Word          = isDual ? w2 : '0;
   assign rapidClass          = cfgRapid;
   // Lamps
   assign readyLamp           = 1'b1;
   assign fault_lamp          = ~isDual & ~isOut & lamp1;
   assign chan1_fault_lamp    = isDual & lamp1;
   assign chan2_fault_lamp    = isDual & lamp2;
   assign fast_delay_lamp     = ~isOut & cfgRapid;
   assign delay_class_lamp    = isOut & cfgRapid;
   assign clear_on_fault_lamp = cfgClear;
   assign fault_bit_mode_lamp = cfgMode;
endmodule

// File: rlcs_term.sv
`timescale 1ns/1ps
module rlcs_term
   import rlcs_pkg::*;
(
   // Bench side
   input  wire logic              ref_clk,
   input  wire logic              send,
   input  wire logic [WORD_W-1:0] data,
   // Link side
   output logic      [WORD_W-1:0] word,
   output logic                   valid
);
   // Word lines toggle between frames, so a stale word never looks fresh
   always_ff @(posedge ref_clk) begin
      valid <= send;
      word  <= send ? data : ~word;
   end
endmodule

// File: rlcs_checker.sv
`timescale 1ns/1ps
module rlcs_checker
   import rlcs_pkg::*;
(
   // Watched ports
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic [SW_W-1:0]   switches,
   input wire logic              link1Fault,
   input wire logic              link1Rapid,
   input wire logic [WORD_W-1:0] input1Word,
   input wire logic              readyLamp,
   input wire logic              fault_lamp,
   input wire logic              fast_delay_lamp,
   input wire logic              clear_on_fault_lamp,
   input wire logic              fault_bit_mode_lamp,
   input wire logic              rapidClass,
   input wire logic [WORD_W-1:0] input2Word,
   input wire logic              chan1_fault_lamp,
   input wire logic              chan2_fault_lamp,
   input wire logic              delay_class_lamp
);
   logic [SW_W-1:0] cap;              // Bank as taken
   logic [1:0]      age;              // Settling count, lamps may lag a stage
   wire             ok = age == 2'h3;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Bank is taken at each edge in reset and last at the first edge out of reset
   always_ff @(posedge ref_clk) begin
      age <= rst ? 2'h0 : age + {1'b0, !ok};
      if (age == 2'h0) cap <= switches;
   end
   ready_lamp_a: assert property (readyLamp) else $error("ready lamp dark");
   fast_lamp_a: assert property (ok |-> fast_delay_lamp == cap[3])
      else $error("fast lamp wrong");
   clear_lamp_a: assert property (ok |-> clear_on_fault_lamp == cap[2])
      else $error("clear lamp wrong");
   mode_lamp_a: assert property (ok |-> fault_bit_mode_lamp == cap[1])
      else $error("mode lamp wrong");
   fault_lamp_a: assert property (ok && (link1Fault || link1Rapid != cap[3]) |=>
      fault_lamp == cap[0]) else $error("fault lamp wrong");
   lamp_gate_a: assert property (ok && !cap[0] |-> !fault_lamp)
      else $error("lamp not gated");
   input_clear_a: assert property (ok && link1Fault && cap[2] |=>
      input1Word[14:0] == 15'h0000) else $error("inputs not cleared");
   fault_flag_a: assert property (ok && link1Fault && cap[1] |=> input1Word[FAULT_BIT])
      else $error("fault bit missing");
   class_out_a: assert property (ok |-> rapidClass == cap[3])
      else $error("delay class output wrong");
   single_unused_a: assert property (ok |-> !chan1_fault_lamp && !chan2_fault_lamp &&
      !delay_class_lamp && input2Word == 16'h0000) else $error("other variant outputs active");
   cover property (ok && link1Fault && cap[2]);
   cover property (ok && link1Rapid != cap[3] && cap[1]);
   cover property (ok && fault_lamp);
endmodule
bind rlcs_top rlcs_checker i_rlcs_checker (.*);

// File: tb.sv
`timescale 1ns/1ps
module tb;
   import rlcs_pkg::*;
   logic              ref_clk = 1'b0, rst = 1'b1, send = 1'b0, brk = 1'b0, rap = 1'b0, en = 1'b1;
   logic [SW_W-1:0]   sw = 6'h00;
   logic [WORD_W-1:0] data = 16'h0000, lWord, word1;
   logic              lValid, ready, fLamp, dLamp, cLamp, mLamp;
   logic [20:0]       notes[$];                   // Expected lamps and word
   int                miscompares = 0, n_tests = 0;
   always #5 ref_clk = ~ref_clk;
   rlcs_term i_rlcs_term (.ref_clk(ref_clk), .send(send), .data(data), .word(lWord),
      .valid(lValid));
   rlcs_top #(.VARIANT(RLCS_VAR_SINGLE), .EST_CYCLES(20)) i_rlcs_top (.ref_clk(ref_clk),
      .rst(rst), .clkEn(en), .switches(sw), .link1Word(lWord), .link1Valid(lValid),
      .link1Fault(brk), .link1Rapid(rap), .link2Word(16'h0000), .link2Valid(1'b0),
      .link2Fault(1'b0), .link2Rapid(1'b0), .input1Word(word1), .input2Word(), .rapidClass(),
      .readyLamp(ready), .fault_lamp(fLamp), .fast_delay_lamp(dLamp), .clear_on_fault_lamp(cLamp),
      .fault_bit_mode_lamp(mLamp), .chan1_fault_lamp(), .chan2_fault_lamp(), .delay_class_lamp());
   // Oldest note meets the outputs at the falling edge, once they have settled
   always @(negedge ref_clk) if (notes.size() > 0) begin
      n_tests++;
      if ({fLamp, dLamp, cLamp, mLamp, ready, word1} !== notes.pop_front()) begin
         miscompares++;
         $display("Error at %0t: lamps or word differ", $time);
      end
   end
   // One setting: reset, late switch change, timeout, good word, then a fault
   task automatic run(input logic [SW_W-1:0] s);
      {rst, brk, rap, sw} <= {2'b10, s[3], s};
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      sw <= ~s & 6'h0F; // Too late to take effect
      repeat (3) @(posedge ref_clk);
      en <= 1'b0; // Two frozen edges only push the timeout later
      repeat (2) @(posedge ref_clk);
      en <= 1'b1;
      repeat (20) @(posedge ref_clk);
      notes.push_back({s[0], s[3:1], 1'b1, s[1], 15'h0000});
      {send, data} <= {1'b1, WORD_W'($urandom)};
      @(posedge ref_clk);
      send <= 1'b0;
      // Word is taken at the next edge, the fault flag drops one edge later
      repeat (2) @(posedge ref_clk);
      notes.push_back({1'b0, s[3:1], 1'b1, data & {!s[1], 15'h7FFF}});
      {brk, rap} <= data[0] ? {1'b1, s[3]} : {1'b0, !s[3]}; // Raw fault or class mismatch
      repeat (2) @(posedge ref_clk);
      notes.push_back({s[0], s[3:1], 1'b1, s[1] | (data[15] & !s[2]),
                       data[14:0] & {15{!s[2]}}});
   endtask
   initial begin
      void'($urandom(32'h9BE3));
      @(posedge ref_clk);
      for (int i = 0; i < 16; i++) run(6'(i));
      @(posedge ref_clk);
      stop_test();
   end
   // A full run takes about 600 cycles
   initial begin
      repeat (3000) @(posedge ref_clk);
      miscompares++;
      stop_test();
   end
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
endmodule
